// ---- hw/prt_result_path.sv ----
// Temperature result path: assembly, averaging, offset, format, maximum
// Functional notes
// RULE1 - Add offset to non-error results
// RULE2 - Offset uses currently selected data format
// RULE3 - Averaging control: count 7:0, upper zero
// RULE4 - Average blends fresh reading by shift fraction
// RULE5 - Zero shift count disables averaging
// RULE6 - Internal words: 16-bit, 1/64 degree steps
// RULE7 - Main config bit 6 selects alternate
// RULE8 - Alternate: sign, bits 12..6, sign-filled
// RULE9 - Error codes skip alternate conversion
// RULE10 - Alternate valid result is signed byte
// RULE11 - Error codes keep high byte 80h/81h
// RULE12 - Reading assembled from PECI LSB first
// RULE13 - Word: low byte LSBs, high MSBs
// RULE14 - Commands 0..7 read socket/domain slots
// RULE15 - Command 08h gives signed enabled maximum
// RULE16 - Maximum carries no source information
// RULE17 - Only error detection interprets CPU data
// RULE18 - Error codes 8000h..81FFh, slot codes defined
// RULE19 - 8103h when no maximum exists
// RULE20 - Command 0Ah returns last maximum slot
// RULE21 - Average, then offset, then format; alternate byte here is formed before the offset is added
// RULE22 - First valid reading loads average directly
`timescale 1ns/1ps
`default_nettype none
module prt_result_path
	import prt_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	// PECI engine side (same clock)
	input  wire logic              peci_start,
	input  wire logic [SLOT_W-1:0] peci_slot,
	input  wire logic              peci_bit_valid,
	input  wire logic              peci_bit,
	input  wire logic              peci_fail,
	// Command side (I2C framing lives outside)
	input  wire logic              cmd_valid,
	input  wire logic              cmd_write,
	input  wire logic [7:0]        cmd_code,
	input  wire logic [WORD_W-1:0] cmd_wdata,
	output var  logic              rsp_valid,
	output var  logic [WORD_W-1:0] rsp_data,
	output var  logic [7:0]        slot_enable,
	output var  logic              assembler_busy
);

	// ==========================================================
	// Helper functions
	// Error code window 8000h..81FFh
	function automatic logic is_err(input logic [WORD_W-1:0] w);
		is_err = (w[15:9] == ERR_TOP); // RULE18 RULE17
	endfunction : is_err

	// ==========================================================
	// Storage
	prt_state_t        state;                  // Assembler state
	logic [WORD_W-1:0] shift_word;             // Word being assembled
	logic [CNT_W-1:0]  bit_cnt;                // Bits taken so far
	logic [SLOT_W-1:0] cur_slot;               // Slot being polled
	logic [WORD_W-1:0] slot_temp [NUM_SLOTS];  // Averaged words
	logic [NUM_SLOTS-1:0] primed;              // Average holds a valid
	logic [WORD_W-1:0] main_cfg;               // Main configuration
	logic [WORD_W-1:0] offset_reg;             // Temperature offset
	logic [7:0]        avg_shift;              // Averaging shift count
	logic [WORD_W-1:0] max_addr;               // Last maximum slot
	logic              max_called;             // Last maximum read found one

	// ==========================================================
	// Assembler: shift LSB first, 16 bits per reading
	wire bits_full = (bit_cnt == CNT_W'(WORD_W));
	wire take_bit  = (state == PRT_SHIFT) && peci_bit_valid && !bits_full;
	wire take_fail = (state != PRT_STORE) && peci_fail;
	prt_state_t next_state;

	always_comb begin
		next_state = state;
		unique case (state)
			PRT_IDLE: begin
				if (peci_start) begin
					next_state = PRT_SHIFT;
				end
			end
			PRT_SHIFT: begin
				if (take_fail) begin
					next_state = PRT_IDLE; // Abandon partial word
				end else if (bits_full) begin
					next_state = PRT_STORE;
				end
			end
			PRT_STORE: begin
				next_state = PRT_IDLE;
			end
		endcase
	end

	// State and bit counter
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state   <= PRT_IDLE;
			bit_cnt <= '0;
		end else begin
			state <= next_state;
			if (state == PRT_IDLE) begin
				bit_cnt <= '0;
			end else if (take_bit) begin
				bit_cnt <= bit_cnt + CNT_W'(1);
			end
		end
	end

	// Data shift and slot latch
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			shift_word <= '0;
			cur_slot   <= '0;
		end else begin
			if (state == PRT_IDLE && peci_start) begin
				cur_slot <= peci_slot;
			end
			if (take_bit) begin
				shift_word <= {peci_bit, shift_word[15:1]}; // RULE12
			end
		end
	end

	// ==========================================================
	// Averaging on the stored 16-bit words
	wire [WORD_W-1:0] old_word = slot_temp[cur_slot];
	wire signed [16:0] avg_diff = $signed({shift_word[15], shift_word})
		- $signed({old_word[15], old_word});
	// Low bits drop out of the step; accepted loss of resolution
	wire signed [16:0] avg_step = avg_diff >>> avg_shift; // RULE4
	wire [WORD_W-1:0] avg_word = old_word + avg_step[15:0];
	// Fresh word bypasses blending when off, unprimed or an error
	wire load_direct = (avg_shift == AVG_RST) || !primed[cur_slot]
		|| is_err(shift_word) || is_err(old_word); // RULE5 RULE22
	wire [WORD_W-1:0] next_temp = load_direct ? shift_word : avg_word;
	wire store_now = (state == PRT_STORE);

	// Slot words restart as "first poll pending"
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_SLOTS; i++) begin
				slot_temp[i] <= ERR_NO_POLL; // RULE18
			end
			primed <= '0;
		end else if (store_now) begin
			slot_temp[cur_slot] <= next_temp; // RULE6 RULE21
			primed[cur_slot]    <= !is_err(shift_word); // RULE22
		end else if (take_fail) begin
			slot_temp[cur_slot] <= ERR_RETRY; // RULE18
			primed[cur_slot]    <= 1'b0;
		end
	end

	// ==========================================================
	// Readout: offset on 16-bit words; alternate byte formed first, then offset added
	wire alt_fmt = main_cfg[ALT_BIT]; // RULE7
	wire [NUM_SLOTS-1:0] en_mask = main_cfg[EN_LSB +: NUM_SLOTS];
	logic [WORD_W-1:0] slot_res [NUM_SLOTS];

	genvar g;
	generate
		for (g = 0; g < NUM_SLOTS; g++) begin : g_res
			wire [WORD_W-1:0] raw = slot_temp[g];
			wire [WORD_W-1:0] sum16 = raw + offset_reg; // RULE1
			// Alternate byte: sign then whole-degree bits
			wire [7:0] alt_lo = {raw[SIGN_BIT], raw[12:ONE_DEG_BIT]}; // RULE8
			// Offset read in the alternate units when selected
			wire [7:0] sum8 = alt_lo + offset_reg[7:0]; // RULE2
			wire [WORD_W-1:0] alt_word = {{8{sum8[7]}}, sum8}; // RULE10
			wire [WORD_W-1:0] fmt = alt_fmt ? alt_word : sum16;
			assign slot_res[g] = !en_mask[g] ? ERR_DISABLED
				: is_err(raw) ? raw : fmt; // RULE9 RULE11
		end
	endgenerate

	// ==========================================================
	// Signed maximum over enabled, non-error slots
	logic [WORD_W-1:0] max_val;
	logic [WORD_W-1:0] max_idx;
	logic              max_found;

	always_comb begin
		max_val   = ERR_NO_MAX;
		max_idx   = ERR_NO_MAX;
		max_found = 1'b0;
		for (int i = 0; i < NUM_SLOTS; i++) begin
			if (!is_err(slot_res[i]) && (!max_found
				|| $signed(slot_res[i]) > $signed(max_val))) begin
				max_val   = slot_res[i]; // RULE15 RULE16
				max_idx   = WORD_W'(i);
				max_found = 1'b1;
			end
		end
	end

	// ==========================================================
	// Command decode
	wire rd_req    = cmd_valid && !cmd_write;
	wire wr_req    = cmd_valid && cmd_write;
	wire is_slot   = (cmd_code <= CMD_SLOT_LAST);
	wire is_max    = (cmd_code == CMD_MAX);
	wire [WORD_W-1:0] addr_word = max_called ? max_addr : ERR_NO_MAX;
	wire [WORD_W-1:0] next_rsp =
		is_slot ? slot_res[cmd_code[SLOT_W-1:0]] : // RULE14 RULE13
		is_max ? (max_found ? max_val : ERR_NO_MAX) : // RULE19
		(cmd_code == CMD_MAX_ADDR) ? addr_word : // RULE20 RULE19
		(cmd_code == CMD_MAIN_CFG) ? main_cfg :
		(cmd_code == CMD_OFFSET) ? offset_reg :
		(cmd_code == CMD_AVG) ? {8'h00, avg_shift} : // RULE3
		UNMAPPED_RD;

	// Configuration writes; reserved averaging bits are not kept
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			main_cfg   <= MAIN_CFG_RST;
			offset_reg <= OFFSET_RST;
			avg_shift  <= AVG_RST; // RULE3
		end else if (wr_req) begin
			if (cmd_code == CMD_MAIN_CFG) begin
				main_cfg <= cmd_wdata;
			end
			if (cmd_code == CMD_OFFSET) begin
				offset_reg <= cmd_wdata;
			end
			if (cmd_code == CMD_AVG) begin
				avg_shift <= cmd_wdata[7:0]; // RULE3
			end
		end
	end

	// Maximum read remembers its source; error maximum forgets it
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			max_addr   <= ERR_NO_MAX;
			max_called <= 1'b0;
		end else if (rd_req && is_max) begin
			max_addr   <= max_idx; // RULE20
			max_called <= max_found; // RULE19
		end
	end

	// Registered answer, one cycle after the request
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rsp_valid      <= 1'b0;
			rsp_data       <= '0;
			slot_enable    <= '0;
			assembler_busy <= 1'b0;
		end else begin
			rsp_valid      <= rd_req;
			slot_enable    <= en_mask;
			assembler_busy <= (next_state != PRT_IDLE);
			if (rd_req) begin
				rsp_data <= next_rsp;
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_rsp_one_cycle: // RULE14
		assert property (rd_req |=> rsp_valid ##1 !rsp_valid || $past(rd_req))
		else $error("read answer not one cycle later");
	a_max_none_code: // RULE19
		assert property (rd_req && is_max && !max_found
			|=> rsp_data == ERR_NO_MAX)
		else $error("empty maximum did not give 8103h");
	a_avg_off_load: // RULE5
		assert property (store_now && avg_shift == AVG_RST
			|=> slot_temp[cur_slot] == $past(shift_word))
		else $error("zero shift did not store fresh word");
	a_first_load: // RULE22
		assert property (store_now && !primed[cur_slot]
			|=> slot_temp[cur_slot] == $past(shift_word))
		else $error("first reading was blended");
	// Slot taken from the failing cycle; a start in IDLE moves cur_slot
	a_fail_code: // RULE18
		assert property (take_fail
			|=> slot_temp[$past(cur_slot)] == ERR_RETRY)
		else $error("failed poll did not store 8100h");
	a_err_high_byte: // RULE11
		assert property (rd_req && is_slot
			&& is_err(slot_res[cmd_code[SLOT_W-1:0]])
			|=> rsp_data[15:9] == ERR_TOP)
		else $error("error code lost its high byte");
	a_alt_sign_fill: // RULE10
		assert property (rd_req && is_slot && alt_fmt
			&& !is_err(slot_res[cmd_code[SLOT_W-1:0]])
			|=> rsp_data[15:8] == {8{rsp_data[7]}})
		else $error("alternate high byte not sign filled");
	a_offset_add: // RULE1
		assert property (rd_req && is_slot && !alt_fmt
			&& en_mask[cmd_code[SLOT_W-1:0]]
			&& !is_err(slot_temp[cmd_code[SLOT_W-1:0]])
			|=> rsp_data == $past(WORD_W'(
				slot_temp[cmd_code[SLOT_W-1:0]] + offset_reg)))
		else $error("offset not added in 16-bit format");
	a_avg_reserved: // RULE3
		assert property (rd_req && cmd_code == CMD_AVG
			|=> rsp_data[15:8] == 8'h00)
		else $error("averaging reserved bits not zero");
	a_lsb_first: // RULE12
		assert property (take_bit |=> shift_word[15] == $past(peci_bit))
		else $error("bit not entered at the top");

	c_full_poll:
		cover property (state == PRT_SHIFT ##[1:64] store_now);
	c_max_found:
		cover property (rd_req && is_max && max_found);
	c_blend:
		cover property (store_now && !load_direct);
	c_alt_read:
		cover property (rd_req && is_slot && alt_fmt);

endmodule : prt_result_path
`default_nettype wire

// ---- hw/prt_pkg.sv ----
// Constants shared by the temperature result path
package prt_pkg;
	// ==========================================================
	// Widths and slot count
	localparam int unsigned WORD_W    = 16;
	localparam int unsigned NUM_SLOTS = 8;
	localparam int unsigned SLOT_W    = 3;
	localparam int unsigned CNT_W     = 5;

	// ==========================================================
	// Command bytes (register addresses)
	localparam logic [7:0] CMD_SLOT_LAST = 8'h07;
	localparam logic [7:0] CMD_MAX       = 8'h08;
	localparam logic [7:0] CMD_MAX_ADDR  = 8'h0a;
	localparam logic [7:0] CMD_MAIN_CFG  = 8'h0c;
	localparam logic [7:0] CMD_OFFSET    = 8'h0e;
	localparam logic [7:0] CMD_AVG       = 8'h0f;

	// ==========================================================
	// Reset values and field positions
	localparam logic [15:0] MAIN_CFG_RST = 16'h00a5;
	localparam logic [15:0] OFFSET_RST   = 16'h0000;
	localparam logic [7:0]  AVG_RST      = 8'h00;
	localparam int unsigned ALT_BIT      = 6;
	localparam int unsigned EN_LSB       = 8;
	localparam int unsigned SIGN_BIT     = 15;
	localparam int unsigned ONE_DEG_BIT  = 6;

	// ==========================================================
	// Error codes and the unmapped read value
	localparam logic [6:0]  ERR_TOP      = 7'h40;
	localparam logic [15:0] ERR_RETRY    = 16'h8100;
	localparam logic [15:0] ERR_DISABLED = 16'h8101;
	localparam logic [15:0] ERR_NO_POLL  = 16'h8102;
	localparam logic [15:0] ERR_NO_MAX   = 16'h8103;
	localparam logic [15:0] UNMAPPED_RD  = 16'h0000;

	// ==========================================================
	// Assembler states
	typedef enum logic [2:0] {
		PRT_IDLE  = 3'b001,
		PRT_SHIFT = 3'b010,
		PRT_STORE = 3'b100
	} prt_state_t;
endpackage : prt_pkg

// ---- verif/prt_host_model.sv ----
// Command-side host model: one word request at a time, result on answer
`timescale 1ns/1ps
`default_nettype none
module prt_host_model
	import prt_pkg::*;
(
	input  wire logic              sys_clk,
	output var  logic              cmd_valid,
	output var  logic              cmd_write,
	output var  logic [7:0]        cmd_code,
	output var  logic [WORD_W-1:0] cmd_wdata,
	input  wire logic              rsp_valid,
	input  wire logic [WORD_W-1:0] rsp_data
);
	// ==========================================================
	// Idle levels at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code  = 8'h55;
		cmd_wdata = 16'h5a5a;
	end

	// ==========================================================
	// One request; released lines show inverted junk, never stale data
	task automatic xfer(input logic wr, input logic [7:0] code,
		input logic [WORD_W-1:0] wd, output logic [WORD_W-1:0] rd,
		output bit ok);
		int n;
		ok = 1'b1;
		rd = 16'h0000;
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_code  <= code;
		cmd_wdata <= wd;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		cmd_code  <= ~code;
		cmd_wdata <= ~wd;
		if (!wr) begin
			// Answer is registered on the taking edge itself
			#1;
			for (n = 0; n < 4 && rsp_valid !== 1'b1; n++) begin
				@(posedge sys_clk);
				#1;
			end
			ok = (rsp_valid === 1'b1);
			rd = rsp_data;
		end
	endtask : xfer
endmodule : prt_host_model
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the temperature result path
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import prt_pkg::*;
	logic              sys_clk = 1'b0;
	logic              sys_rst = 1'b1;
	logic              peci_start = 1'b0;
	logic [SLOT_W-1:0] peci_slot = 3'h0;
	logic              peci_bit_valid = 1'b0;
	logic              peci_bit = 1'b0;
	logic              peci_fail = 1'b0;
	logic              cmd_valid, cmd_write;
	logic [7:0]        cmd_code, slot_enable;
	logic [WORD_W-1:0] cmd_wdata, rsp_data;
	logic              rsp_valid, assembler_busy;
	int                fail_count = 0;
	int                checked = 0;

	// ==========================================================
	// Clock, design and host
	always #12.5 sys_clk = ~sys_clk;
	prt_result_path dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.peci_start(peci_start), .peci_slot(peci_slot),
		.peci_bit_valid(peci_bit_valid), .peci_bit(peci_bit),
		.peci_fail(peci_fail), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .slot_enable(slot_enable),
		.assembler_busy(assembler_busy));
	prt_host_model host_u (.sys_clk(sys_clk), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data));

	// ==========================================================
	// Compare, report and access tasks
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up
	task automatic rd(input logic [7:0] code, input logic [15:0] exp);
		logic [15:0] d;
		bit          ok;
		host_u.xfer(1'b0, code, 16'h0000, d, ok);
		check({15'h0, ok}, 16'h0001);
		check(d, exp);
		// A missing answer is a timeout: stop at the report
		if (!ok) wrap_up();
	endtask : rd
	task automatic wr(input logic [7:0] code, input logic [15:0] data);
		logic [15:0] d;
		bit          ok;
		host_u.xfer(1'b1, code, data, d, ok);
	endtask : wr
	// Bounded wait for the assembler to go idle
	task automatic idle_wait();
		int n;
		for (n = 0; n < 40 && assembler_busy !== 1'b0; n++)
			@(posedge sys_clk);
		if (assembler_busy !== 1'b0) begin
			fail_count++;
			wrap_up();
		end else begin
			repeat (2) @(posedge sys_clk);
		end
	endtask : idle_wait
	// One reading sent least significant bit first
	task automatic peci(input logic [2:0] slot, input logic [15:0] w);
		int i;
		@(posedge sys_clk);
		peci_start <= 1'b1;
		peci_slot  <= slot;
		@(posedge sys_clk);
		peci_start <= 1'b0;
		for (i = 0; i < 16; i++) begin
			peci_bit_valid <= 1'b1;
			peci_bit       <= w[i];
			@(posedge sys_clk);
		end
		peci_bit_valid <= 1'b0;
		peci_bit       <= ~w[15];
		idle_wait();
	endtask : peci

	// ==========================================================
	// Main sequence
	initial begin
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		// Reset values and empty answers
		rd(8'h0c, 16'h00a5);
		rd(8'h0e, 16'h0000);
		rd(8'h0f, 16'h0000);
		rd(8'h00, 16'h8101);
		rd(8'h0b, 16'h0000);
		rd(8'h08, 16'h8103);
		rd(8'h0a, 16'h8103);
		$display("test reset done");
		// Enable slots 0, 3, 5; the enable copy lags one cycle
		wr(8'h0c, 16'h29a5);
		@(posedge sys_clk);
		#1;
		check({8'h00, slot_enable}, 16'h0029);
		// Serial assembly and slot addressing
		peci(3'd3, 16'hffc0);
		peci(3'd5, 16'hf700);
		rd(8'h03, 16'hffc0);
		rd(8'h05, 16'hf700);
		$display("test assembly done");
		// Offset on valid words only
		wr(8'h0e, 16'h17c0);
		rd(8'h03, 16'h1780);
		rd(8'h00, 16'h8102);
		// Maximum over enabled slots 0, 3, 5
		rd(8'h08, 16'h1780);
		rd(8'h0a, 16'h0003);
		$display("test offset and maximum done");
		// Alternate format with offset in that format
		wr(8'h0c, 16'h29e5);
		wr(8'h0e, 16'h005f);
		rd(8'h03, 16'h005e);
		rd(8'h05, 16'h003b);
		rd(8'h00, 16'h8102);
		$display("test alternate done");
		// Averaging, reserved bits dropped
		wr(8'h0c, 16'h29a5);
		wr(8'h0e, 16'h0000);
		wr(8'h0f, 16'hff01);
		rd(8'h0f, 16'h0001);
		peci(3'd3, 16'h0040);
		rd(8'h03, 16'h0000);
		wr(8'h0f, 16'h0000);
		peci(3'd3, 16'h0100);
		rd(8'h03, 16'h0100);
		// Failure before the first bit of a reading, then direct load after error
		@(posedge sys_clk);
		peci_start <= 1'b1;
		peci_slot  <= 3'd5;
		@(posedge sys_clk);
		peci_start <= 1'b0;
		peci_fail  <= 1'b1;
		@(posedge sys_clk);
		peci_fail <= 1'b0;
		idle_wait();
		rd(8'h05, 16'h8100);
		rd(8'h08, 16'h0100);
		wr(8'h0f, 16'h0001);
		peci(3'd5, 16'h0200);
		rd(8'h05, 16'h0200);
		$display("test averaging done");
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
